// [i2c_bus_peer.sv]
module i2c_bus_peer (
    // controller pin
    input  wire logic scl_oe,
    // other masters and slaves
    input  wire logic hold_scl,
    input  wire logic pull_sda,
    // wired lines
    output logic      scl_line,
    output logic      sda_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-ups restore released lines
    assign scl_line = !(scl_oe || hold_scl);
    assign sda_line = !pull_sda;
endmodule

// [i2c_fe_pkg.sv]
package i2c_fe_pkg;

    // geometry
    localparam int NCH   = 2;
    localparam int NSLOT = 3;
    localparam int AW    = 20;
    localparam int FILT_STAGES = 3;

    // register map, channel 1 sits one stride above channel 0
    localparam logic [AW-1:0] FE_ADDR   = 20'h88305;
    localparam logic [AW-1:0] ADE_ADDR  = 20'h88306;
    localparam logic [AW-1:0] STAT_ADDR = 20'h8830F;
    localparam logic [AW-1:0] CH_STRIDE = 20'h00020;

    // reset values and writable masks
    localparam logic [7:0] FE_RST    = 8'h72;
    localparam logic [7:0] ADE_RST   = 8'h09;
    localparam logic [7:0] FE_WMASK  = 8'h7F;
    localparam logic [7:0] ADE_WMASK = 8'hAF;

    // fixed address patterns
    localparam logic [6:0] GC_ADDR    = 7'h00;
    localparam logic [6:0] DEVID_ADDR = 7'h7C;
    localparam logic [6:0] HOST_ADDR  = 7'h08;
    localparam logic       RW_WRITE   = 1'h0;

    // timeout terminal counts
    localparam logic [15:0] TMO_LONG_MAX  = 16'hFFFF;
    localparam logic [13:0] TMO_SHORT_MAX = 14'h3FFF;

    typedef struct packed {
        logic rsvd7;
        logic scl_sync_en;
        logic digital_filter_en;
        logic nack_suspend_en;
        logic slave_arb_lost_det_en;
        logic nack_tx_arb_lost_en;
        logic master_arb_lost_det_en;
        logic timeout_func_en;
    } func_en_t;

    typedef struct packed {
        logic host_addr_en;
        logic rsvd6;
        logic device_id_det_en;
        logic rsvd4;
        logic general_call_en;
        logic addr_slot2_en;
        logic addr_slot1_en;
        logic addr_slot0_en;
    } addr_en_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic       transmit;
        logic       master;
        logic       nack_susp;
        logic       arb_lost;
        logic       timeout;
    } stat_t;

    typedef struct packed {
        logic load;
        logic master;
        logic tx;
    } mode_t;

    typedef struct packed {
        logic smp;
        logic drv;
        logic ack_slot;
    } bitev_t;

    typedef struct packed {
        logic       vld;
        logic       first;
        logic [7:0] data;
    } frame_t;

    typedef struct packed {
        logic             host;
        logic             devid;
        logic             gcall;
        logic [NSLOT-1:0] slot;
    } hit_t;

    typedef enum logic [1:0] {
        SG_IDLE = 2'b00,
        SG_LOW  = 2'b01,
        SG_WAIT = 2'b10,
        SG_HIGH = 2'b11
    } sg_state_t;

    function automatic logic [AW-1:0] ch_ofs(input int c);
        return CH_STRIDE * AW'(c);
    endfunction

endpackage

// [i2c_function_address_enable.sv]
// Functional notes
// - timeout detection runs only when enabled
// - master arbitration loss clears master, transmit flags
// - ACK seen while sending NACK loses arbitration
// - slave transmit mismatch loses arbitration
// - received NACK suspends next transfer when enabled
// - suspension disabled: transfers continue regardless
// - noise filter used only when enabled
// - generated SCL follows sensed SCL when synced
// - unsynced SCL uses programmed widths only
// - reserved bits read zero, software writes zero
// - function enable resets to 0x72
// - address detect enable resets to 0x09
// - two channels at separate addresses
// - enabled slots compare received address
// - disabled slots ignored even on match
// - general call recognised when enabled
// - general call ignored when disabled
// - device-ID first frame recognised when enabled
// - device-ID disabled: frame is ordinary address
// - host address recognised with SMBus and enable
// - host address ignored unless both set
// - SMBus selection makes host enable effective
// - timeout counter 16 bit long, 14 short
//
// Decided for this implementation: the address-and-strobe port.
module i2c_function_address_enable
    import i2c_fe_pkg::*;
(
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // register port
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_we,
    input  wire logic          reg_re,
    output logic      [7:0]    reg_rdata,
    // bus pins
    input  wire logic          scl_in             [NCH],
    input  wire logic          sda_in             [NCH],
    output logic               scl_out            [NCH],
    output logic               scl_oe             [NCH],
    // settings held outside this block
    input  wire logic          smbus_select       [NCH],
    input  wire logic          timeout_length_sel [NCH],
    input  wire logic [7:0]    scl_high_width     [NCH],
    input  wire logic [7:0]    scl_low_width      [NCH],
    input  wire logic [6:0]    slot_addr          [NCH][NSLOT],
    // protocol engine side
    input  wire logic          scl_gen_run        [NCH],
    input  wire mode_t         mode_in            [NCH],
    input  wire bitev_t        bit_ev             [NCH],
    input  wire logic          resume             [NCH],
    input  wire frame_t        frame              [NCH],
    output logic               scl_filt           [NCH],
    output logic               sda_filt           [NCH],
    output logic               master_flag        [NCH],
    output logic               transmit_flag      [NCH],
    output logic               arb_lost           [NCH],
    output logic               nack_susp          [NCH],
    output logic               timeout_det        [NCH],
    output hit_t               addr_hit           [NCH],
    output logic               addr_hit_vld       [NCH]
);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic [7:0] fe_q   [NCH];
    logic [7:0] ade_q  [NCH];
    logic [7:0] stat_v [NCH];

    // read port, data valid only the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (reg_re) begin
                for (int c = 0; c < NCH; c++) begin
                    if (reg_addr == FE_ADDR + ch_ofs(c)) begin
                        reg_rdata <= fe_q[c];
                    end
                    if (reg_addr == ADE_ADDR + ch_ofs(c)) begin
                        reg_rdata <= ade_q[c];
                    end
                    if (reg_addr == STAT_ADDR + ch_ofs(c)) begin
                        reg_rdata <= stat_v[c];
                    end
                end
            end
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        localparam logic [AW-1:0] OFS = ch_ofs(c);

        func_en_t        fe;
        addr_en_t        ade;
        logic [FILT_STAGES-1:0] scl_hist_q;
        logic [FILT_STAGES-1:0] sda_hist_q;
        logic [15:0]     tmo_cnt_q;
        logic            scl_prev_q;
        logic            tmo_hit;
        logic            lost_m;
        logic            lost_n;
        logic            lost_s;
        logic            nack_rx;
        sg_state_t       sg_q;
        logic [7:0]      sg_cnt_q;
        logic [6:0]      f_addr;
        logic            f_rw;
        logic            devid_m;
        logic [NSLOT-1:0] slot_en;
        logic [NSLOT-1:0] slot_m;
        logic            tmo_st_q;
        logic            arb_st_q;
        logic            stat_rd;

        assign fe      = func_en_t'(fe_q[c]);
        assign ade     = addr_en_t'(ade_q[c]);
        assign stat_rd = reg_re && (reg_addr == STAT_ADDR + OFS);
        assign stat_v[c] = stat_t'({3'h0, transmit_flag[c], master_flag[c],
                                    nack_susp[c], arb_st_q, tmo_st_q});

        // enable registers; reserved bits masked off on write
        always_ff @(posedge mclk) begin
            if (rst) begin
                fe_q[c] <= FE_RST;
            end else if (reg_we && reg_addr == FE_ADDR + OFS) begin
                fe_q[c] <= reg_wdata & FE_WMASK;
            end
        end

        always_ff @(posedge mclk) begin
            if (rst) begin
                ade_q[c] <= ADE_RST;
            end else if (reg_we && reg_addr == ADE_ADDR + OFS) begin
                ade_q[c] <= reg_wdata & ADE_WMASK;
            end
        end

        // digital noise filter: when enabled, output moves only on agreeing samples; bypassed, it follows each input sample
        always_ff @(posedge mclk) begin
            if (rst) begin
                scl_hist_q  <= '1;
                sda_hist_q  <= '1;
                scl_filt[c] <= 1'h1;
                sda_filt[c] <= 1'h1;
            end else begin
                scl_hist_q <= {scl_hist_q[FILT_STAGES-2:0], scl_in[c]};
                sda_hist_q <= {sda_hist_q[FILT_STAGES-2:0], sda_in[c]};
                if (!fe.digital_filter_en) begin
                    scl_filt[c] <= scl_in[c];
                    sda_filt[c] <= sda_in[c];
                end else begin
                    if (&scl_hist_q) scl_filt[c] <= 1'h1;
                    if (~|scl_hist_q) scl_filt[c] <= 1'h0;
                    if (&sda_hist_q) sda_filt[c] <= 1'h1;
                    if (~|sda_hist_q) sda_filt[c] <= 1'h0;
                end
            end
        end

        // timeout: counts while scl holds one level
        assign tmo_hit = fe.timeout_func_en && scl_filt[c] == scl_prev_q &&
                         (timeout_length_sel[c]
                          ? tmo_cnt_q[$bits(TMO_SHORT_MAX)-1:0] == TMO_SHORT_MAX
                          : tmo_cnt_q == TMO_LONG_MAX);

        always_ff @(posedge mclk) begin
            if (rst) begin
                tmo_cnt_q      <= '0;
                scl_prev_q     <= 1'h1;
                timeout_det[c] <= 1'h0;
            end else begin
                scl_prev_q     <= scl_filt[c];
                timeout_det[c] <= tmo_hit;
                if (!fe.timeout_func_en || scl_filt[c] != scl_prev_q) begin
                    tmo_cnt_q <= '0;
                end else begin
                    tmo_cnt_q <= tmo_cnt_q + 16'h0001;
                end
            end
        end

        // arbitration-lost detection
        assign lost_m = fe.master_arb_lost_det_en && master_flag[c] &&
                        transmit_flag[c] && bit_ev[c].smp && !bit_ev[c].ack_slot &&
                        bit_ev[c].drv && !sda_filt[c];
        assign lost_n = fe.nack_tx_arb_lost_en && !transmit_flag[c] &&
                        bit_ev[c].smp && bit_ev[c].ack_slot &&
                        bit_ev[c].drv && !sda_filt[c];
        assign lost_s = fe.slave_arb_lost_det_en && !master_flag[c] &&
                        transmit_flag[c] && bit_ev[c].smp && !bit_ev[c].ack_slot &&
                        bit_ev[c].drv != sda_filt[c];
        assign nack_rx = transmit_flag[c] && bit_ev[c].smp &&
                         bit_ev[c].ack_slot && sda_filt[c];

        always_ff @(posedge mclk) begin
            if (rst) begin
                master_flag[c]   <= 1'h0;
                transmit_flag[c] <= 1'h0;
            end else if (mode_in[c].load) begin
                master_flag[c]   <= mode_in[c].master;
                transmit_flag[c] <= mode_in[c].tx;
            end else if (lost_m) begin
                master_flag[c]   <= 1'h0;
                transmit_flag[c] <= 1'h0;
            end
        end

        always_ff @(posedge mclk) begin
            if (rst) begin
                arb_lost[c] <= 1'h0;
            end else begin
                arb_lost[c] <= lost_m || lost_n || lost_s;
            end
        end

        // suspension holds until the engine resumes; a new nack wins
        always_ff @(posedge mclk) begin
            if (rst) begin
                nack_susp[c] <= 1'h0;
            end else if (fe.nack_suspend_en && nack_rx) begin
                nack_susp[c] <= 1'h1;
            end else if (resume[c]) begin
                nack_susp[c] <= 1'h0;
            end
        end

        // scl generator, open drain: drive low or release
        always_ff @(posedge mclk) begin
            if (rst) begin
                sg_q       <= SG_IDLE;
                sg_cnt_q   <= '0;
                scl_oe[c]  <= 1'h0;
                scl_out[c] <= 1'h0;
            end else begin
                scl_out[c] <= 1'h0;
                case (sg_q)
                    SG_IDLE: begin
                        scl_oe[c] <= 1'h0;
                        sg_cnt_q  <= '0;
                        if (scl_gen_run[c]) begin
                            sg_q      <= SG_LOW;
                            scl_oe[c] <= 1'h1;
                        end
                    end
                    SG_LOW: begin
                        sg_cnt_q <= sg_cnt_q + 8'h01;
                        if (sg_cnt_q >= scl_low_width[c]) begin
                            scl_oe[c] <= 1'h0;
                            sg_cnt_q  <= '0;
                            sg_q      <= fe.scl_sync_en ? SG_WAIT : SG_HIGH;
                        end
                    end
                    SG_WAIT: begin
                        if (scl_filt[c]) begin
                            sg_q <= SG_HIGH;
                        end
                    end
                    SG_HIGH: begin
                        sg_cnt_q <= sg_cnt_q + 8'h01;
                        if (fe.scl_sync_en && !scl_filt[c]) begin
                            sg_q      <= SG_LOW;
                            sg_cnt_q  <= '0;
                            scl_oe[c] <= 1'h1;
                        end else if (sg_cnt_q >= scl_high_width[c]) begin
                            sg_cnt_q  <= '0;
                            sg_q      <= scl_gen_run[c] ? SG_LOW : SG_IDLE;
                            scl_oe[c] <= scl_gen_run[c];
                        end
                    end
                    default: begin
                        sg_q      <= SG_IDLE;
                        scl_oe[c] <= 1'h0;
                    end
                endcase
            end
        end

        // address recognition
        assign f_addr  = frame[c].data[7:1];
        assign f_rw    = frame[c].data[0];
        assign devid_m = ade.device_id_det_en && frame[c].first &&
                         f_addr == DEVID_ADDR;
        assign slot_en = {ade.addr_slot2_en, ade.addr_slot1_en, ade.addr_slot0_en};

        always_comb begin
            slot_m = '0;
            for (int s = 0; s < NSLOT; s++) begin
                slot_m[s] = slot_en[s] && !devid_m &&
                            f_addr == slot_addr[c][s];
            end
        end

        always_ff @(posedge mclk) begin
            if (rst) begin
                addr_hit[c]     <= '0;
                addr_hit_vld[c] <= 1'h0;
            end else begin
                addr_hit_vld[c] <= frame[c].vld;
                if (frame[c].vld) begin
                    addr_hit[c].slot  <= slot_m;
                    addr_hit[c].devid <= devid_m;
                    addr_hit[c].gcall <= ade.general_call_en && f_addr == GC_ADDR &&
                                         f_rw == RW_WRITE;
                    addr_hit[c].host  <= smbus_select[c] && ade.host_addr_en &&
                                         f_addr == HOST_ADDR;
                end
            end
        end

        // sticky status, cleared on read; a new event wins over the clear
        always_ff @(posedge mclk) begin
            if (rst) begin
                tmo_st_q <= 1'h0;
                arb_st_q <= 1'h0;
            end else begin
                tmo_st_q <= tmo_hit || (tmo_st_q && !stat_rd);
                arb_st_q <= lost_m || lost_n || lost_s || (arb_st_q && !stat_rd);
            end
        end

        sequence s_low_done;
            sg_q == SG_LOW && sg_cnt_q >= scl_low_width[c];
        endsequence

        sequence s_nack_seen;
            fe.nack_suspend_en && nack_rx;
        endsequence

        a_tmo_gate: assert property (!fe.timeout_func_en |=> !timeout_det[c])
            else $error("timeout reported while disabled");
        a_master_loss_clear: assert property (lost_m && !mode_in[c].load
                |=> !master_flag[c] && !transmit_flag[c] && arb_lost[c])
            else $error("master flags not cleared on loss");
        a_nack_tx_lost: assert property (fe.nack_tx_arb_lost_en && !transmit_flag[c] &&
                bit_ev[c].smp && bit_ev[c].ack_slot && bit_ev[c].drv && !sda_filt[c]
                |=> arb_lost[c])
            else $error("ack during nack not flagged");
        a_slave_mismatch: assert property (fe.slave_arb_lost_det_en && !master_flag[c] &&
                transmit_flag[c] && bit_ev[c].smp && !bit_ev[c].ack_slot &&
                bit_ev[c].drv != sda_filt[c] |=> arb_lost[c])
            else $error("slave mismatch not flagged");
        a_nack_hold: assert property (s_nack_seen |=> nack_susp[c] ##1
                (nack_susp[c] || $past(resume[c])))
            else $error("suspension not held");
        a_suspend_off: assert property (!fe.nack_suspend_en && !nack_susp[c]
                |=> !nack_susp[c])
            else $error("suspended while disabled");
        a_filter_byp: assert property (!fe.digital_filter_en
                |=> scl_filt[c] == $past(scl_in[c]))
            else $error("filter not bypassed");
        a_scl_sync: assert property (s_low_done ##0 fe.scl_sync_en
                |=> sg_q == SG_WAIT ##0 !scl_oe[c])
            else $error("sync wait skipped");
        a_wait_line: assert property (sg_q == SG_WAIT && !scl_filt[c]
                |=> sg_q == SG_WAIT)
            else $error("high phase before line high");
        a_scl_free: assert property (s_low_done ##0 !fe.scl_sync_en
                |=> sg_q == SG_HIGH)
            else $error("unsynced clock waited on line");
        a_rsvd_zero: assert property (!fe.rsvd7 && !ade.rsvd6 && !ade.rsvd4)
            else $error("reserved bit set");
        a_reset_vals: assert property ($past(rst) |-> fe_q[c] == FE_RST &&
                ade_q[c] == ADE_RST)
            else $error("wrong reset value");
        a_slot_gate: assert property (frame[c].vld && !slot_en[0]
                |=> addr_hit_vld[c] && !addr_hit[c].slot[0])
            else $error("disabled slot matched");
        a_gcall_hit: assert property (frame[c].vld && f_addr == GC_ADDR && !f_rw
                |=> addr_hit[c].gcall == $past(ade.general_call_en))
            else $error("general call decision wrong");
        a_host_gate: assert property (frame[c].vld && f_addr == HOST_ADDR
                |=> addr_hit[c].host == $past(smbus_select[c] && ade.host_addr_en))
            else $error("host address decision wrong");
    end

endmodule

// [testbench.sv]
module testbench
    import i2c_fe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] ade;
        logic       smb;
        logic       first;
        logic [7:0] b;
        logic [5:0] hit;
    } arow_t;
    typedef struct packed {
        logic [7:0] fe;
        logic       m, t, drv, ack, sda, arb, nack;
    } brow_t;
    logic          mclk = 1'b0;
    logic          rst = 1'b1;
    logic [AW-1:0] reg_addr = '0;
    logic [7:0]    reg_wdata = '0;
    logic          reg_we = 1'b0;
    logic          reg_re = 1'b0;
    logic [7:0]    reg_rdata;
    logic          scl_in [NCH], sda_in [NCH], scl_out [NCH], scl_oe [NCH];
    logic          smbus_select [NCH] = '{default: 1'b0};
    logic          timeout_length_sel [NCH] = '{default: 1'b0};
    logic [7:0]    scl_high_width [NCH] = '{default: 8'h03};
    logic [7:0]    scl_low_width [NCH] = '{default: 8'h03};
    logic [6:0]    slot_addr [NCH][NSLOT] = '{'{7'h7C, 7'h21, 7'h35}, '{default: 7'h00}};
    logic          scl_gen_run [NCH] = '{default: 1'b0};
    mode_t         mode_in [NCH] = '{default: '0};
    bitev_t        bit_ev [NCH] = '{default: '0};
    logic          resume [NCH] = '{default: 1'b0};
    frame_t        frame [NCH] = '{default: '0};
    logic          scl_filt [NCH], sda_filt [NCH], master_flag [NCH], transmit_flag [NCH];
    logic          arb_lost [NCH], nack_susp [NCH], timeout_det [NCH], addr_hit_vld [NCH];
    hit_t          addr_hit [NCH];
    logic          hold_scl = 1'b0;
    logic          pull_sda = 1'b0;
    logic          scl_line, sda_line;
    int            failures = 0;
    int            checks = 0;
    int            cycles = 0;
    int            n;
    arow_t at [13] = '{
        '{8'h09, 1'b0, 1'b1, 8'hF8, 6'h01}, '{8'h09, 1'b0, 1'b0, 8'h42, 6'h00},
        '{8'h07, 1'b0, 1'b0, 8'h42, 6'h02}, '{8'h07, 1'b0, 1'b0, 8'h6B, 6'h04},
        '{8'h09, 1'b0, 1'b0, 8'h00, 6'h08}, '{8'h00, 1'b0, 1'b0, 8'h00, 6'h00},
        '{8'h00, 1'b0, 1'b1, 8'hF8, 6'h00}, '{8'h21, 1'b0, 1'b1, 8'hF8, 6'h10},
        '{8'h21, 1'b0, 1'b0, 8'hF8, 6'h01}, '{8'h80, 1'b1, 1'b0, 8'h10, 6'h20},
        '{8'h80, 1'b0, 1'b0, 8'h10, 6'h00}, '{8'h00, 1'b1, 1'b0, 8'h10, 6'h00},
        '{8'h09, 1'b0, 1'b0, 8'h01, 6'h00}};
    brow_t bt [8] = '{
        '{8'h72, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0},
        '{8'h70, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{8'h74, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0},
        '{8'h70, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
        '{8'h78, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
        '{8'h70, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
        '{8'h70, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1},
        '{8'h60, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0}};

    assign scl_in[0] = scl_line;
    assign sda_in[0] = sda_line;
    assign scl_in[1] = 1'b1;
    assign sda_in[1] = 1'b1;

    i2c_bus_peer peer (.scl_oe(scl_oe[0]), .hold_scl, .pull_sda, .scl_line, .sda_line);

    i2c_function_address_enable dut (
        .mclk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .scl_in, .sda_in, .scl_out, .scl_oe, .smbus_select, .timeout_length_sel,
        .scl_high_width, .scl_low_width, .slot_addr, .scl_gen_run, .mode_in, .bit_ev,
        .resume, .frame, .scl_filt, .sda_filt, .master_flag, .transmit_flag, .arb_lost,
        .nack_susp, .timeout_det, .addr_hit, .addr_hit_vld);

    always #4 mclk = ~mclk;

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
    endtask

    task automatic reg_wr(input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge mclk);
        reg_we <= 1'b0;
    endtask

    task automatic reg_rd(input logic [AW-1:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge mclk);
        reg_re <= 1'b0;
        #1 check(what, 16'(reg_rdata), 16'(exp));
    endtask

    task automatic glitch(input int k, input logic exp);
        logic low;
        low = 1'b0;
        @(posedge mclk);
        hold_scl <= 1'b1;
        step(k);
        hold_scl <= 1'b0;
        repeat (8) begin
            #1 low |= !scl_filt[0];
            @(posedge mclk);
        end
        check("filter glitch", 16'(low), 16'(exp));
    endtask

    // line held low by another master while our generator runs
    task automatic gen_run(input int exp);
        int cnt;
        cnt = 0;
        @(posedge mclk);
        hold_scl <= 1'b1;
        scl_gen_run[0] <= 1'b1;
        for (int i = 0; i < 10 && scl_oe[0] !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        repeat (24) begin
            cnt += int'(scl_oe[0]);
            @(posedge mclk);
            #1;
        end
        check("scl low cycles", 16'(cnt), 16'(exp));
        check("scl out", 16'(scl_out[0]), 16'h0000);
        @(posedge mclk);
        scl_gen_run[0] <= 1'b0;
        hold_scl <= 1'b0;
        step(20);
    endtask

    initial begin
        step(10);
        rst <= 1'b0;
        reg_rd(FE_ADDR, 8'h72, "fe0 reset");
        reg_rd(ADE_ADDR, 8'h09, "ade0 reset");
        reg_rd(FE_ADDR + CH_STRIDE, 8'h72, "fe1 reset");
        reg_rd(ADE_ADDR + CH_STRIDE, 8'h09, "ade1 reset");
        reg_wr(FE_ADDR + CH_STRIDE, 8'hFF);
        reg_rd(FE_ADDR + CH_STRIDE, 8'h7F, "fe1 readback");
        reg_wr(ADE_ADDR + CH_STRIDE, 8'hFF);
        reg_rd(ADE_ADDR + CH_STRIDE, 8'hAF, "ade1 readback");
        reg_rd(FE_ADDR, 8'h72, "fe0 untouched");
        reg_rd(20'h88300, 8'h00, "unmapped");
        glitch(2, 1'b0);
        reg_wr(FE_ADDR, 8'h52);
        glitch(1, 1'b1);
        reg_wr(FE_ADDR, 8'h72);
        gen_run(4);
        reg_wr(FE_ADDR, 8'h32);
        gen_run(12);
        reg_wr(FE_ADDR, 8'h72);
        foreach (at[i]) begin
            reg_wr(ADE_ADDR, at[i].ade);
            @(posedge mclk);
            smbus_select[0] <= at[i].smb;
            frame[0] <= '{1'b1, at[i].first, at[i].b};
            @(posedge mclk);
            frame[0] <= '0;
            #1 check("addr hit", 16'({addr_hit_vld[0], addr_hit[0]}),
                16'({1'b1, at[i].hit}));
        end
        foreach (bt[i]) begin
            reg_wr(FE_ADDR, bt[i].fe);
            @(posedge mclk);
            mode_in[0] <= '{1'b1, bt[i].m, bt[i].t};
            pull_sda <= !bt[i].sda;
            resume[0] <= 1'b1;
            @(posedge mclk);
            mode_in[0].load <= 1'b0;
            resume[0] <= 1'b0;
            step(5);
            bit_ev[0] <= '{1'b1, bt[i].drv, bt[i].ack};
            @(posedge mclk);
            bit_ev[0].smp <= 1'b0;
            #1 check("arb lost", 16'(arb_lost[0]), 16'(bt[i].arb));
            @(posedge mclk);
            #1 check("flags", 16'({master_flag[0], transmit_flag[0], nack_susp[0]}),
                16'({bt[i].m & !bt[i].arb, bt[i].t & !(bt[i].arb & bt[i].m),
                bt[i].nack}));
        end
        pull_sda <= 1'b0;
        timeout_length_sel[0] <= 1'b1;
        reg_wr(FE_ADDR, 8'h73);
        n = 0;
        while (timeout_det[0] !== 1'b1 && n < 17000) begin
            @(posedge mclk);
            #1 n++;
        end
        check("short timeout", 16'(n > 16370 && n < 16400), 16'h0001);
        reg_rd(STAT_ADDR, 8'h1B, "status sticky");
        reg_rd(STAT_ADDR, 8'h18, "status cleared");
        reg_wr(FE_ADDR, 8'h72);
        n = 0;
        repeat (17000) begin
            @(posedge mclk);
            #1 n += int'(timeout_det[0] === 1'b1);
        end
        check("timeout off", 16'(n), 16'h0000);
        complete_run();
    end
endmodule
